// ==== div_cfg_pkg.sv ====
`default_nettype none

package div_cfg_pkg;

	// ---------------------------------------------------------------
	// Set geometry
	// ---------------------------------------------------------------
	localparam int SET_COUNT = 4;
	localparam int SEL_W     = 2;
	localparam int REF_W     = 2;
	localparam int WHOLE_W   = 7;
	localparam int FRAC_W    = 18;
	localparam int POST_W    = 7;
	localparam int FBDIV_W   = WHOLE_W + 1;

	typedef struct packed {
		logic [REF_W-1:0]   ref_div;
		logic [WHOLE_W-1:0] fb_whole;
		logic [FRAC_W-1:0]  fb_frac;
		logic [POST_W-1:0]  post_div;
	} div_set_s;

	typedef struct packed {
		logic             en;
		logic [SEL_W-1:0] idx;
		div_set_s         set;
	} set_wr_s;

	// ---------------------------------------------------------------
	// Serial register map: address = {3'b000, set[1:0], field[2:0]}
	// ---------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR_DEF   = 7'h6e;
	localparam int         ADDR_SET_LSB   = 3;
	localparam logic [2:0] FLD_REF        = 3'h0;
	localparam logic [2:0] FLD_WHOLE      = 3'h1;
	localparam logic [2:0] FLD_POST       = 3'h2;
	localparam logic [2:0] FLD_FRAC_HI    = 3'h3;
	localparam logic [2:0] FLD_FRAC_MID   = 3'h4;
	localparam logic [2:0] FLD_FRAC_LO    = 3'h5;
	localparam logic [2:0] ADDR_PAGE_MAP  = 3'h0;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;
	localparam logic [7:0] PTR_RST        = 8'h00;

	// ---------------------------------------------------------------
	// Reference variants and presets
	// ---------------------------------------------------------------
	localparam longint XTAL_FREQ_A_HZ = 64'd114285000;
	localparam longint XTAL_FREQ_B_HZ = 64'd100000000;
	localparam logic [SEL_W-1:0] SEL_RST = 2'h0;

	localparam div_set_s PRESET_DEF [SET_COUNT] = '{
		'{ref_div: 2'h1, fb_whole: 7'h19, fb_frac: 18'h00000, post_div: 7'h14},
		'{ref_div: 2'h1, fb_whole: 7'h1b, fb_frac: 18'h10000, post_div: 7'h12},
		'{ref_div: 2'h1, fb_whole: 7'h1c, fb_frac: 18'h20000, post_div: 7'h10},
		'{ref_div: 2'h2, fb_whole: 7'h1e, fb_frac: 18'h30000, post_div: 7'h08}
	};

	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} ser_state_e;

endpackage

`default_nettype wire

// ==== div_cfg_bank.sv ====
`default_nettype none

module div_cfg_bank
	import div_cfg_pkg::*;
#(
	parameter div_set_s PRESETS [SET_COUNT] = PRESET_DEF
) (
	input  wire logic             clk_sys,
	input  wire logic             nrst,
	input  wire set_wr_s          wr,
	input  wire logic [SEL_W-1:0] rd_idx,
	input  wire logic [SEL_W-1:0] sel,
	output div_set_s              rd_set,
	output div_set_s              active
);

	// ---------------------------------------------------------------
	// Storage, volatile: reset is the power-up load
	// ---------------------------------------------------------------
	div_set_s sets_r [SET_COUNT];

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < SET_COUNT; i++) begin
				sets_r[i] <= PRESETS[i];
			end
		end else if (wr.en) begin
			sets_r[wr.idx] <= wr.set;
		end
	end

	assign rd_set = sets_r[rd_idx];

	// ---------------------------------------------------------------
	// Output mux
	// ---------------------------------------------------------------
	// Only the chosen set reaches the synthesizer, so writes elsewhere are harmless
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			active <= PRESETS[SEL_RST];
		end else begin
			active <= sets_r[sel];
		end
	end

endmodule

`default_nettype wire

// ==== divider_config_select.sv ====
// Contract
// - Keep four divider sets; the two select pins choose the one applied.
// - Select 00..11 picks set 0..3; each set has all four divider fields.
// - Power-up loads presets into all sets; pins pick the applied set.
// - Every set can be read back over the two-wire serial port.
// - Controller may rewrite any set; a rewritten set applies when selected.
// - Storage is volatile; each power-up restores the presets.
// - A select pin change switches dividers at once, no serial command needed.
// - Fields: 2-bit reference, 7-bit post, 7-bit whole, 18-bit fraction.
// - Output equals reference over reference times post, times whole plus half-offset fraction.
// - Reference frequency is one of two fixed values, per variant.
// - Fractional feedback is produced by a delta-sigma modulator.

`default_nettype none

module divider_config_select
	import div_cfg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
	parameter div_set_s   PRESETS [SET_COUNT] = PRESET_DEF
) (
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               config_select_low,
	input  wire logic               config_select_high,
	input  wire logic               serial_clock_pin,
	input  wire logic               serial_data_pin,
	output logic                    serial_data_out,
	output logic                    serial_data_oe_n,
	output logic [SEL_W-1:0]        select_applied,
	output div_set_s                active_set,
	output logic [FBDIV_W-1:0]      fb_divide
);

	// ---------------------------------------------------------------
	// Byte access to a set
	// ---------------------------------------------------------------
	function automatic logic [7:0] get_byte(
		input div_set_s   s,
		input logic [2:0] fld
	);
		logic [7:0] b;
		b = UNMAPPED_READ;
		unique case (fld)
			FLD_REF:      b = {6'h00, s.ref_div};
			FLD_WHOLE:    b = {1'b0, s.fb_whole};
			FLD_POST:     b = {1'b0, s.post_div};
			FLD_FRAC_HI:  b = {6'h00, s.fb_frac[17:16]};
			FLD_FRAC_MID: b = s.fb_frac[15:8];
			FLD_FRAC_LO:  b = s.fb_frac[7:0];
			default:      b = UNMAPPED_READ;
		endcase
		return b;
	endfunction

	function automatic div_set_s put_byte(
		input div_set_s   s,
		input logic [2:0] fld,
		input logic [7:0] d
	);
		div_set_s r;
		r = s;
		unique case (fld)
			FLD_REF:      r.ref_div = d[1:0];
			FLD_WHOLE:    r.fb_whole = d[6:0];
			FLD_POST:     r.post_div = d[6:0];
			FLD_FRAC_HI:  r.fb_frac[17:16] = d[1:0];
			FLD_FRAC_MID: r.fb_frac[15:8] = d;
			FLD_FRAC_LO:  r.fb_frac[7:0] = d;
			default:      r = s;
		endcase
		return r;
	endfunction

	function automatic logic in_map(
		input logic [7:0] a
	);
		return a[7:5] == ADDR_PAGE_MAP;
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Bits: 0 clock, 1 data, 2 select low, 3 select high
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	logic [1:0] prev_r;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_r <= {SEL_RST, 2'b11};
			sync_r <= {SEL_RST, 2'b11};
		end else begin
			meta_r <= {config_select_high, config_select_low, serial_data_pin, serial_clock_pin};
			sync_r <= meta_r;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prev_r <= 2'b11;
		end else begin
			prev_r <= sync_r[1:0];
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	assign scl_s    = sync_r[0];
	assign sda_s    = sync_r[1];
	assign scl_rise = scl_s & ~prev_r[0];
	assign scl_fall = ~scl_s & prev_r[0];
	assign start_c  = scl_s & prev_r[0] & prev_r[1] & ~sda_s;
	assign stop_c   = scl_s & prev_r[0] & ~prev_r[1] & sda_s;

	// ---------------------------------------------------------------
	// Serial slave state
	// ---------------------------------------------------------------
	ser_state_e state_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic       rw_r;
	logic       mack_r;
	logic       byte_end;
	logic       rd_end;
	logic       addr_hit;
	div_set_s   rd_set;
	logic [7:0] rd_byte;

	assign byte_end = scl_fall && (cnt_r == 4'h8);
	assign rd_end   = byte_end && (state_r == ST_RD);
	assign addr_hit = shift_r[7:1] == DEV_ADDR;
	assign rd_byte  = in_map(ptr_r) ? get_byte(rd_set, ptr_r[2:0]) : UNMAPPED_READ;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
			shift_r <= 8'h00;
			rw_r    <= 1'b0;
			mack_r  <= 1'b0;
		end else if (stop_c) begin
			state_r <= ST_IDLE;
		end else if (start_c) begin
			state_r <= ST_ADDR;
			cnt_r   <= 4'h0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					cnt_r <= 4'h0;
				end
				ST_ADDR, ST_PTR, ST_WR: begin
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_s};
						cnt_r   <= cnt_r + 4'h1;
					end else if (byte_end) begin
						cnt_r <= 4'h0;
						if (state_r == ST_ADDR) begin
							rw_r    <= shift_r[0];
							state_r <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
						end else if (state_r == ST_PTR) begin
							state_r <= ST_PTR_ACK;
						end else begin
							state_r <= ST_WR_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw_r) begin
							state_r <= ST_RD;
							shift_r <= rd_byte;
						end else begin
							state_r <= ST_PTR;
						end
					end
				end
				ST_PTR_ACK, ST_WR_ACK: begin
					if (scl_fall) begin
						state_r <= ST_WR;
					end
				end
				ST_RD: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (rd_end) begin
						cnt_r   <= 4'h0;
						state_r <= ST_RD_ACK;
					end else if (scl_fall) begin
						shift_r <= {shift_r[6:0], 1'b0};
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						mack_r <= ~sda_s;
					end else if (scl_fall) begin
						if (mack_r) begin
							state_r <= ST_RD;
							shift_r <= rd_byte;
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register pointer, auto-increments per data byte
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ptr_r <= PTR_RST;
		end else if (byte_end && state_r == ST_PTR) begin
			ptr_r <= shift_r;
		end else if ((scl_fall && state_r == ST_WR_ACK) || rd_end) begin
			ptr_r <= ptr_r + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Byte write into a set
	// ---------------------------------------------------------------
	// Read-modify-write of one field; unmapped bytes are acked and dropped
	set_wr_s wr_r;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_r <= '0;
		end else begin
			wr_r.en  <= byte_end && state_r == ST_WR && in_map(ptr_r);
			wr_r.idx <= ptr_r[ADDR_SET_LSB +: SEL_W];
			wr_r.set <= put_byte(rd_set, ptr_r[2:0], shift_r);
		end
	end

	// ---------------------------------------------------------------
	// Open-drain data pin
	// ---------------------------------------------------------------
	logic drive_low;

	assign drive_low = (state_r == ST_ADDR_ACK) || (state_r == ST_PTR_ACK) || (state_r == ST_WR_ACK)
		|| (state_r == ST_RD && !shift_r[7]);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			serial_data_oe_n <= 1'b1;
		end else begin
			serial_data_oe_n <= ~drive_low;
		end
	end

	assign serial_data_out = 1'b0;

	// ---------------------------------------------------------------
	// Configuration bank
	// ---------------------------------------------------------------
	// Pins act with no serial command; two sync stages plus one output register of delay
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			select_applied <= SEL_RST;
		end else begin
			select_applied <= sync_r[3:2];
		end
	end

	div_cfg_bank #(
		.PRESETS (PRESETS)
	) u_bank (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.wr      (wr_r),
		.rd_idx  (ptr_r[ADDR_SET_LSB +: SEL_W]),
		.sel     (sync_r[3:2]),
		.rd_set  (rd_set),
		.active  (active_set)
	);

	// ---------------------------------------------------------------
	// Fractional feedback modulator
	// ---------------------------------------------------------------
	// First-order accumulator; the forced LSB adds the half-step offset,
	// so the mean divide is whole + (frac + 0.5) / 2^18. Higher-order
	// shaping is left to the analog loop.
	logic [FRAC_W:0]   acc_r;
	logic [FRAC_W+1:0] acc_sum;

	assign acc_sum = {1'b0, acc_r} + {1'b0, active_set.fb_frac, 1'b1};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_sum[FRAC_W:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fb_divide <= '0;
		end else begin
			fb_divide <= {1'b0, active_set.fb_whole} + {{WHOLE_W{1'b0}}, acc_sum[FRAC_W+1]};
		end
	end

endmodule

`default_nettype wire

// ==== div_cfg_props.sv ====
`default_nettype none

module div_cfg_props
	import div_cfg_pkg::*;
(
	input wire logic		clk_sys,
	input wire logic		nrst,
	input wire logic		config_select_low,
	input wire logic		config_select_high,
	input wire logic		serial_clock_pin,
	input wire logic		serial_data_pin,
	input wire logic		serial_data_out,
	input wire logic		serial_data_oe_n,
	input wire logic [SEL_W-1:0]	select_applied,
	input wire div_set_s		active_set,
	input wire logic [FBDIV_W-1:0]	fb_divide
);
	// ------------------------------------------
	// Select path and serial pin checks
	// ------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic [2:0]	up_r;
	logic [7:0]	low_r;
	logic		arm_r;
	// Unknown at the first edge, before any reset has acted, so that edge is skipped
	always_ff @(posedge clk_sys) begin
		arm_r <= 1'b1;
	end
	wire logic [1:0]	pins = {config_select_high, config_select_low};
	wire logic [6:0]	whole_w = active_set.fb_whole;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) up_r <= 3'h0;
		else if (up_r != 3'h7) up_r <= up_r + 3'h1;
	end
	// Run length of a pulled-low data line
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) low_r <= 8'h00;
		else if (serial_data_oe_n) low_r <= 8'h00;
		else if (low_r != 8'hff) low_r <= low_r + 8'h01;
	end
	sequence s_pins_held; $stable(pins)[*4]; endsequence
	sequence s_sel_moved; select_applied != $past(select_applied); endsequence
	property p_rst_vals; disable iff (1'b0) arm_r && !nrst |-> serial_data_oe_n && select_applied == SEL_RST
		&& active_set == PRESET_DEF[0] && fb_divide == 8'h00; endproperty
	property p_sel_lat; up_r == 3'h7 ##0 s_pins_held |-> select_applied == pins; endproperty
	property p_sel_early; up_r < 3'h3 |-> select_applied == SEL_RST; endproperty
	property p_act_quiet; up_r == 3'h7 && $changed(active_set) |-> s_sel_moved; endproperty
	property p_fb_rel; up_r == 3'h7 |-> fb_divide == {1'b0, $past(whole_w)}
		|| fb_divide == {1'b0, $past(whole_w)} + 8'h01; endproperty
	property p_sdo; serial_data_out == 1'b0; endproperty
	property p_oe_edge; $changed(serial_data_oe_n) |-> !serial_clock_pin; endproperty
	// Longest pull: an ack and then a zero read byte, nine bit times
	property p_oe_len; low_r < 8'h98; endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset state wrong");
	a_sel_lat: assert property (p_sel_lat) else $error("select not applied");
	a_sel_early: assert property (p_sel_early) else $error("select early");
	a_act_quiet: assert property (p_act_quiet) else $error("active set disturbed");
	a_fb_rel: assert property (p_fb_rel) else $error("feedback divide wrong");
	a_sdo: assert property (p_sdo) else $error("data out not low");
	a_oe_edge: assert property (p_oe_edge) else $error("data moved with clock high");
	a_oe_len: assert property (p_oe_len) else $error("data line held too long");
endmodule

bind divider_config_select div_cfg_props u_props (.clk_sys(clk_sys), .nrst(nrst),
	.config_select_low(config_select_low), .config_select_high(config_select_high),
	.serial_clock_pin(serial_clock_pin), .serial_data_pin(serial_data_pin),
	.serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n),
	.select_applied(select_applied), .active_set(active_set), .fb_divide(fb_divide));

`default_nettype wire

// ==== i2c_host_model.sv ====
`default_nettype none

module i2c_host_model (
	input wire logic	clk_sys,
	output logic		scl,
	output logic		sda_m,
	input wire logic	sda_w
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------
	// Bus master, 8 clocks per half bit
	// ------------------------------------------
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic start();
		sda_m = 1'b1;
		tk(4);
		scl = 1'b1;
		tk(4);
		sda_m = 1'b0;
		tk(4);
		scl = 1'b0;
		tk(4);
	endtask
	task automatic stop();
		sda_m = 1'b0;
		tk(4);
		scl = 1'b1;
		tk(4);
		sda_m = 1'b1;
		tk(4);
	endtask
	// Data only moves while the clock is low
	task automatic bit_io(input logic b, output logic r);
		sda_m = b;
		tk(4);
		scl = 1'b1;
		tk(4);
		r = sda_w;
		tk(4);
		scl = 1'b0;
		tk(4);
	endtask
	task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
		bit_io(a, k);
	endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import div_cfg_pkg::*;
	logic		clk_sys = 1'b0;
	logic		nrst = 1'b0;
	logic [1:0]	pins = 2'h0;
	logic		scl, sda_m, sdo, oe_n;
	logic [1:0]	sel_app;
	div_set_s	act;
	logic [7:0]	fbd;
	int		bad_count = 0, compares = 0, cyc = 0;
	// Open drain with pull-up: low if either side pulls
	wire logic	sda_w = sda_m & (oe_n | sdo);

	divider_config_select DUT (.clk_sys(clk_sys), .nrst(nrst), .config_select_low(pins[0]),
		.config_select_high(pins[1]), .serial_clock_pin(scl), .serial_data_pin(sda_w),
		.serial_data_out(sdo), .serial_data_oe_n(oe_n), .select_applied(sel_app),
		.active_set(act), .fb_divide(fbd));
	i2c_host_model M (.clk_sys(clk_sys), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));

	// ------------------------------------------
	// Helpers
	// ------------------------------------------
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] fb(input div_set_s s, input logic [7:0] a);
		if (a[7:5] != 3'h0) return 8'h00;
		case (a[2:0])
			3'h0: return {6'h00, s.ref_div};
			3'h1: return {1'b0, s.fb_whole};
			3'h2: return {1'b0, s.post_div};
			3'h3: return {6'h00, s.fb_frac[17:16]};
			3'h4: return s.fb_frac[15:8];
			3'h5: return s.fb_frac[7:0];
			default: return 8'h00;
		endcase
	endfunction
	task automatic rst(input logic [1:0] p);
		nrst = 1'b0;
		pins = p;
		M.tk(10);
		nrst = 1'b1;
		M.tk(6);
	endtask
	task automatic set_pins(input logic [1:0] p);
		pins = p;
		M.tk(5);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic k;
		M.start();
		M.xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, r, k);
		chk(k, 1'b0);
		M.xfer(a, 1'b1, r, k);
		M.xfer(d, 1'b1, r, k);
		chk(k, 1'b0);
		M.stop();
	endtask
	// Pointer write, repeated start, burst read
	task automatic rd_set(input logic [7:0] ptr, input div_set_s e, input int n);
		logic [7:0] r;
		logic k;
		M.start();
		M.xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, r, k);
		M.xfer(ptr, 1'b1, r, k);
		M.start();
		M.xfer({DEV_ADDR_DEF, 1'b1}, 1'b1, r, k);
		chk(k, 1'b0);
		for (int f = 0; f < n; f++) begin
			M.xfer(8'hff, f == n - 1, r, k);
			chk(r, fb(e, ptr + 8'(f)));
		end
		M.stop();
	endtask

	initial begin
		div_set_s nw;
		logic [7:0] r;
		logic k;
		nw = '{ref_div: 2'h3, fb_whole: 7'h55, fb_frac: 18'h2a5c3, post_div: 7'h7f};
		rst(2'h2);
		chk(sel_app, 2'h2);
		chk(act, PRESET_DEF[2]);
		for (int i = 0; i < 4; i++) begin
			set_pins(2'(i));
			chk(act, PRESET_DEF[i]);
		end
		rd_set(8'h18, PRESET_DEF[3], 6);
		set_pins(2'h0);
		for (int f = 0; f < 6; f++) wreg({3'h0, 2'h2, 3'(f)}, fb(nw, 8'(f)));
		chk(act, PRESET_DEF[0]);
		set_pins(2'h2);
		chk(act, nw);
		rd_set(8'h10, nw, 6);
		wreg(8'h06, 8'h5a);
		rd_set(8'h06, nw, 1);
		rd_set(8'h20, nw, 1);
		M.start();
		M.xfer({DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1, r, k);
		chk(k, 1'b1);
		M.stop();
		rst(2'h2);
		chk(act, PRESET_DEF[2]);
		rd_set(8'h10, PRESET_DEF[2], 6);
		report_and_stop();
	end
endmodule

`default_nettype wire
